/* verilog/input_mux_pkg.sv */
package input_mux_pkg;

    // Ten terminals on each of the two pulse I/O modules.
    localparam int TERMS_PER_MOD = 10;
    localparam int NUM_MOD = 2;
    localparam int NUM_TERM = 20;
    localparam int NUM_FAST = 4;
    localparam int CFG_W = 16;
    localparam int WORD_W = 10;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] OFS_CFG0 = 8'h00;
    localparam logic [7:0] OFS_CFG1 = 8'h04;
    localparam logic [7:0] OFS_WORD0 = 8'h08;
    localparam logic [7:0] OFS_WORD1 = 8'h0C;
    localparam logic [7:0] OFS_CONFLICT = 8'h10;

    // Configuration word fields, one word per module.
    localparam int F_OP = 0;
    localparam int OP_W = 2;
    localparam int F_ORIGIN = 8;
    localparam int F_ZRST = 10;
    localparam int F_POSDONE = 12;
    localparam int F_PHASE = 14;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

    // Terminal positions inside a module.
    localparam int T_ZRST_FIRST = 2;
    localparam int T_POSDONE_FIRST = 4;
    localparam int T_PHASE_FIRST = 6;
    localparam int T_PHASE_SECOND = 8;

    // Input operation codes for terminals 00 to 03.
    localparam logic [OP_W-1:0] OP_NORMAL = 2'h0;
    localparam logic [OP_W-1:0] OP_INTERRUPT = 2'h1;
    localparam logic [OP_W-1:0] OP_QUICK = 2'h2;

    // The one consumer that a terminal feeds.
    typedef enum logic [2:0] {
        FN_NORMAL,
        FN_INTERRUPT,
        FN_QUICK,
        FN_COUNTER_Z,
        FN_ORIGIN,
        FN_POS_DONE,
        FN_PHASE
    } func_t;

endpackage : input_mux_pkg

/* verilog/input_terminal_function_mux.sv */
module input_terminal_function_mux (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [19:0] input_terminal,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [19:0] normal_in,
    output logic [7:0] interrupt_in,
    output logic [7:0] quick_in,
    output logic [3:0] counter_z,
    output logic [3:0] counter_a,
    output logic [3:0] counter_b,
    output logic [3:0] origin_in,
    output logic [3:0] origin_prox,
    output logic [3:0] pos_done
);

    logic [19:0] term_meta;
    logic [19:0] term_s;
    logic [1:0][15:0] cfg;
    logic [1:0][15:0] next_cfg;
    logic [19:0] conflict;
    logic [19:0] next_conflict;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [19:0] next_normal_in;
    logic [7:0] next_interrupt_in;
    logic [7:0] next_quick_in;
    logic [3:0] next_counter_z;
    logic [3:0] next_counter_a;
    logic [3:0] next_counter_b;
    logic [3:0] next_origin_in;
    logic [3:0] next_origin_prox;
    logic [3:0] next_pos_done;
    logic access;
    logic commit;

    // Resolves the function of terminal t under one module's configuration word.
    function automatic input_mux_pkg::func_t term_func(input logic [15:0] c, input int t);
        input_mux_pkg::func_t f;
        logic [1:0] op;
        f = input_mux_pkg::FN_NORMAL;
        op = c[input_mux_pkg::F_OP + input_mux_pkg::OP_W * (t % 4) +: input_mux_pkg::OP_W];
        if (t < input_mux_pkg::T_POSDONE_FIRST)
        begin
            if (c[input_mux_pkg::F_ORIGIN + t / 2])
                f = input_mux_pkg::FN_ORIGIN;
            else if (t >= input_mux_pkg::T_ZRST_FIRST
                     && c[input_mux_pkg::F_ZRST + t - input_mux_pkg::T_ZRST_FIRST])
                f = input_mux_pkg::FN_COUNTER_Z;
            else if (op == input_mux_pkg::OP_INTERRUPT)
                f = input_mux_pkg::FN_INTERRUPT;
            else if (op == input_mux_pkg::OP_QUICK)
                f = input_mux_pkg::FN_QUICK;
        end
        else if (t < input_mux_pkg::T_PHASE_FIRST)
        begin
            if (c[input_mux_pkg::F_POSDONE + t - input_mux_pkg::T_POSDONE_FIRST])
                f = input_mux_pkg::FN_POS_DONE;
        end
        else if (c[input_mux_pkg::F_PHASE + (t - input_mux_pkg::T_PHASE_FIRST) / 2])
            f = input_mux_pkg::FN_PHASE;
        return f;
    endfunction : term_func

    // Flags a terminal for which more than one function was requested at once.
    function automatic logic term_conflict(input logic [15:0] c, input int t);
        logic org;
        logic zr;
        logic opx;
        org = 1'b0;
        zr = 1'b0;
        opx = 1'b0;
        if (t < input_mux_pkg::T_POSDONE_FIRST)
        begin
            org = c[input_mux_pkg::F_ORIGIN + t / 2];
            zr = (t >= input_mux_pkg::T_ZRST_FIRST)
                 && c[input_mux_pkg::F_ZRST + (t % 2)];
            // Op code 3 routes as normal input, so only interrupt and quick requests count.
            opx = c[input_mux_pkg::F_OP + input_mux_pkg::OP_W * (t % 4) +: input_mux_pkg::OP_W]
                  inside {input_mux_pkg::OP_INTERRUPT, input_mux_pkg::OP_QUICK};
        end
        return (org & zr) | (org & opx) | (zr & opx);
    endfunction : term_conflict

    // Two flops on every pin; only the second stage is read by any logic.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            term_meta <= '0;
            term_s <= '0;
        end
        else
        begin
            term_meta <= input_terminal;
            term_s <= term_meta;
        end
    end

    // Each synced terminal is steered to exactly one consumer; all others see zero.
    always_comb
    begin
        input_mux_pkg::func_t f;
        int idx;
        f = input_mux_pkg::FN_NORMAL;
        idx = 0;
        next_normal_in = '0;
        next_interrupt_in = '0;
        next_quick_in = '0;
        next_counter_z = '0;
        next_counter_a = '0;
        next_counter_b = '0;
        next_origin_in = '0;
        next_origin_prox = '0;
        next_pos_done = '0;
        next_conflict = '0;
        for (int m = 0; m < input_mux_pkg::NUM_MOD; m++)
        begin
            for (int t = 0; t < input_mux_pkg::TERMS_PER_MOD; t++)
            begin
                idx = m * input_mux_pkg::TERMS_PER_MOD + t;
                f = term_func(cfg[m], t);
                next_conflict[idx] = term_conflict(cfg[m], t);
                unique case (f)
                    input_mux_pkg::FN_NORMAL: next_normal_in[idx] = term_s[idx];
                    input_mux_pkg::FN_INTERRUPT:
                        next_interrupt_in[m * input_mux_pkg::NUM_FAST + t] = term_s[idx];
                    input_mux_pkg::FN_QUICK:
                        next_quick_in[m * input_mux_pkg::NUM_FAST + t] = term_s[idx];
                    input_mux_pkg::FN_ORIGIN:
                        if (t % 2 == 0)
                            next_origin_in[2 * m + t / 2] = term_s[idx];
                        else
                            next_origin_prox[2 * m + t / 2] = term_s[idx];
                    input_mux_pkg::FN_COUNTER_Z:
                        next_counter_z[2 * m + 3 - t] = term_s[idx];
                    input_mux_pkg::FN_POS_DONE:
                        next_pos_done[2 * m + t - input_mux_pkg::T_POSDONE_FIRST] = term_s[idx];
                    input_mux_pkg::FN_PHASE:
                        if (t % 2 == 0)
                            next_counter_a[2 * m + (t < input_mux_pkg::T_PHASE_SECOND)] = term_s[idx];
                        else
                            next_counter_b[2 * m + (t < input_mux_pkg::T_PHASE_SECOND)] = term_s[idx];
                endcase
            end
        end
    end

    // APB slave: one wait state, so pready rises on the second access cycle.
    assign access = psel & penable & ~pready;
    assign commit = psel & penable & pready;

    always_comb
    begin
        next_cfg = cfg;
        next_pready = access;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (commit && pwrite)
        begin
            if (paddr == input_mux_pkg::OFS_CFG0)
                next_cfg[0] = pwdata[input_mux_pkg::CFG_W-1:0];
            else if (paddr == input_mux_pkg::OFS_CFG1)
                next_cfg[1] = pwdata[input_mux_pkg::CFG_W-1:0];
        end
        if (access)
        begin
            next_prdata = '0;
            unique case (paddr)
                input_mux_pkg::OFS_CFG0: next_prdata[input_mux_pkg::CFG_W-1:0] = cfg[0];
                input_mux_pkg::OFS_CFG1: next_prdata[input_mux_pkg::CFG_W-1:0] = cfg[1];
                input_mux_pkg::OFS_WORD0: next_prdata[input_mux_pkg::WORD_W-1:0] = term_s[9:0];
                input_mux_pkg::OFS_WORD1: next_prdata[input_mux_pkg::WORD_W-1:0] = term_s[19:10];
                input_mux_pkg::OFS_CONFLICT: next_prdata[input_mux_pkg::NUM_TERM-1:0] = conflict;
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    // Registers every output so nothing reaches a pin through logic.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cfg <= {input_mux_pkg::CFG_RESET, input_mux_pkg::CFG_RESET};
            conflict <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            normal_in <= '0;
            interrupt_in <= '0;
            quick_in <= '0;
            counter_z <= '0;
            counter_a <= '0;
            counter_b <= '0;
            origin_in <= '0;
            origin_prox <= '0;
            pos_done <= '0;
        end
        else
        begin
            cfg <= next_cfg;
            conflict <= next_conflict;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            normal_in <= next_normal_in;
            interrupt_in <= next_interrupt_in;
            quick_in <= next_quick_in;
            counter_z <= next_counter_z;
            counter_a <= next_counter_a;
            counter_b <= next_counter_b;
            origin_in <= next_origin_in;
            origin_prox <= next_origin_prox;
            pos_done <= next_pos_done;
        end
    end

    // Checks on routing and the register port.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_wr_cfg0;
        psel && penable && pready && pwrite && paddr == input_mux_pkg::OFS_CFG0;
    endsequence
    property p_cfg_write;
        s_wr_cfg0 |=> cfg[0] == $past(pwdata[15:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("Config write lost.");
    property p_one_func;
        $onehot0({normal_in[2], interrupt_in[2], quick_in[2], counter_z[1], origin_in[1]});
    endproperty
    a_one_func: assert property (p_one_func) else $error("Terminal 02 fans out.");
    property p_word_read;
        psel && penable && pready && !pwrite && paddr == input_mux_pkg::OFS_WORD1
            |-> prdata[9:0] == $past(term_s[19:10]);
    endproperty
    a_word_read: assert property (p_word_read) else $error("Input word 1 wrong.");
    property p_z_mod0;
        cfg[0][11] && !cfg[0][9] |=> counter_z[0] == $past(term_s[3]);
    endproperty
    a_z_mod0: assert property (p_z_mod0) else $error("Counter 0 Z misrouted.");
    property p_z_mod1;
        cfg[1][10] && !cfg[1][9] |=> counter_z[3] == $past(term_s[12]);
    endproperty
    a_z_mod1: assert property (p_z_mod1) else $error("Counter 3 Z misrouted.");
    property p_origin0;
        cfg[0][8] |=> origin_in[0] == $past(term_s[0]) && origin_prox[0] == $past(term_s[1]);
    endproperty
    a_origin0: assert property (p_origin0) else $error("Pulse 0 origin misrouted.");
    property p_origin3;
        cfg[1][9] |=> origin_in[3] == $past(term_s[12]) && origin_prox[3] == $past(term_s[13]);
    endproperty
    a_origin3: assert property (p_origin3) else $error("Pulse 3 origin misrouted.");
    property p_quick2;
        cfg[0][5:4] == input_mux_pkg::OP_QUICK && cfg[0][11:8] == 4'h0
            |=> quick_in[2] == $past(term_s[2]) && !normal_in[2] && !interrupt_in[2];
    endproperty
    a_quick2: assert property (p_quick2) else $error("Quick input 2 wrong.");
    property p_int5;
        cfg[1][3:2] == input_mux_pkg::OP_INTERRUPT && !cfg[1][8]
            |=> interrupt_in[5] == $past(term_s[11]);
    endproperty
    a_int5: assert property (p_int5) else $error("Interrupt 5 misrouted.");
    property p_phase;
        cfg[1][15] |=> counter_a[2] == $past(term_s[18]) && counter_b[2] == $past(term_s[19]);
    endproperty
    a_phase: assert property (p_phase) else $error("Counter 2 phases wrong.");
    property p_no_normal;
        cfg[0][12] |=> !normal_in[4];
    endproperty
    a_no_normal: assert property (p_no_normal) else $error("Normal fed twice.");
    property p_priority;
        cfg[0][9] && cfg[0][10] |=> counter_z[1] == 1'b0 && origin_in[1] == $past(term_s[2]);
    endproperty
    a_priority: assert property (p_priority) else $error("Origin did not win.");

endmodule : input_terminal_function_mux

/* verif/sensor_model.sv */
module sensor_model (
    input wire logic ref_clk,
    input wire logic [19:0] level,
    input wire logic slow,
    output logic [19:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] stage1;
    logic [19:0] stage2;

    // Field devices follow the commanded level after one clock, or after three when slow.
    // The slow path stands for long cables and relay contacts, which lag the controller.
    always @(posedge ref_clk)
    begin
        stage1 <= level;
        stage2 <= stage1;
        pins <= slow ? stage2 : level;
    end
endmodule : sensor_model

/* verif/test_input_terminal_function_mux.sv */
module test_input_terminal_function_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [19:0] level = 20'hFFFFF;
    logic slow = 1'b0;
    logic [19:0] input_terminal;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [19:0] normal_in;
    logic [7:0] interrupt_in, quick_in;
    logic [3:0] counter_z, counter_a, counter_b, origin_in, origin_prox, pos_done;
    logic [32:0] r;
    int errors = 0;
    int n_compared = 0;
    // Rows hold cfg0, cfg1 and the conflict map they raise; row four overlaps on purpose.
    // No interrupt input is paired with a pulse output for feeding here.
    logic [51:0] rows [6] = '{{16'h0000, 16'h0000, 20'h00000}, {16'h0055, 16'h00AA, 20'h00000},
        {16'hFC00, 16'h3C00, 20'h00000}, {16'h03C0, 16'hC000, 20'h00000},
        {16'h0FAA, 16'h0C55, 20'h0300F}, {16'h00E4, 16'hF300, 20'h00000}};
    logic [19:0] pats [3] = '{20'hFFFFF, 20'h5A5C3, 20'hA5A3C};
    wire logic [59:0] got = {normal_in, interrupt_in, quick_in, counter_z, counter_a,
        counter_b, origin_in, origin_prox, pos_done};

    input_terminal_function_mux dut (.ref_clk, .rst, .input_terminal, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .normal_in, .interrupt_in,
        .quick_in, .counter_z, .counter_a, .counter_b, .origin_in, .origin_prox, .pos_done);
    sensor_model field (.ref_clk, .level, .slow, .pins(input_terminal));

    // The clock toggles every 2.5 ns, half of its 5 ns period.
    always #2.5 ref_clk = ~ref_clk;

    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic chk_route(input logic [59:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] routed outputs expected %h seen %h", exp, got);
        end
    endtask : chk_route

    task automatic chk_bus(input string name, input logic [32:0] exp, input logic [32:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk_bus

    // One transfer; with more set the next setup follows at once, so psel stays high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic more);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge ref_clk);
        r = {pslverr, prdata};
        if (pready !== 1'b1)
        begin
            errors++;
            $display("[ERR] pready expected 1 seen %b", pready);
            end_of_test();
        end
        else
        begin
            penable <= 1'b0;
            if (!more)
                psel <= 1'b0;
            if (!more)
                @(posedge ref_clk);
        end
    endtask : apb

    // Waits out the field delay plus the three edges of sync and output register.
    task automatic drive(input logic [19:0] v, input logic s);
        level <= v;
        slow <= s;
        repeat (s ? 7 : 5) @(posedge ref_clk);
    endtask : drive

    // Reference routing; origin search wins over phase Z, which wins over the op field.
    function automatic logic [59:0] model_route(input logic [15:0] c0, c1,
        input logic [19:0] p);
        logic [19:0] nrm;
        logic [7:0] irq, qk;
        logic [3:0] z, a, b, org, prx, pd;
        logic [15:0] c;
        logic [9:0] t, u;
        logic [1:0] op;
        {irq, qk, z, a, b, org, prx, pd} = '0;
        for (int m = 0; m < 2; m++)
        begin
            c = m ? c1 : c0;
            t = p[m*10 +: 10];
            u = {c[15], c[15], c[14], c[14], c[13], c[12], c[11:10] | {2{c[9]}}, c[8], c[8]};
            if (c[8]) {prx[2*m], org[2*m]} = t[1:0];
            if (c[9]) {prx[2*m+1], org[2*m+1]} = t[3:2];
            if (c[10] && !c[9]) z[2*m+1] = t[2];
            if (c[11] && !c[9]) z[2*m] = t[3];
            if (c[12]) pd[2*m] = t[4];
            if (c[13]) pd[2*m+1] = t[5];
            if (c[14]) {b[2*m+1], a[2*m+1]} = t[7:6];
            if (c[15]) {b[2*m], a[2*m]} = t[9:8];
            for (int k = 0; k < 4; k++)
            begin
                op = c[2*k +: 2];
                if (!u[k] && op == input_mux_pkg::OP_INTERRUPT) irq[4*m+k] = t[k];
                if (!u[k] && op == input_mux_pkg::OP_QUICK) qk[4*m+k] = t[k];
                u[k] = u[k] | (op inside {input_mux_pkg::OP_INTERRUPT, input_mux_pkg::OP_QUICK});
            end
            nrm[m*10 +: 10] = t & ~u;
        end
        return {nrm, irq, qk, z, a, b, org, prx, pd};
    endfunction : model_route

    // Reset values first, then table rows, then bus errors, read-only places and a second reset by hand.
    initial
    begin
        logic [15:0] c0, c1;
        repeat (10) @(posedge ref_clk);
        chk_route(60'h0);
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, input_mux_pkg::OFS_CFG0, 32'h0, 1'b1);
        chk_bus("cfg0 reset", 33'h0, r);
        apb(1'b0, input_mux_pkg::OFS_CONFLICT, 32'h0, 1'b0);
        chk_bus("conflict reset", 33'h0, r);
        for (int i = 0; i < 6; i++)
        begin
            {c0, c1} = rows[i][51:20];
            apb(1'b1, input_mux_pkg::OFS_CFG0, {16'hFFFF, c0}, 1'b1);
            apb(1'b1, input_mux_pkg::OFS_CFG1, {16'h0000, c1}, 1'b0);
            apb(1'b0, input_mux_pkg::OFS_CONFLICT, 32'h0, 1'b1);
            chk_bus("conflict", {13'h0, rows[i][19:0]}, r);
            apb(1'b0, input_mux_pkg::OFS_CFG0, 32'h0, 1'b0);
            chk_bus("cfg0", {17'h0, c0}, r);
            for (int j = 0; j < 3; j++)
            begin
                drive(pats[j], j == 2);
                chk_route(model_route(c0, c1, pats[j]));
                apb(1'b0, input_mux_pkg::OFS_WORD0, 32'h0, 1'b1);
                chk_bus("word0", {23'h0, pats[j][9:0]}, r);
                apb(1'b0, input_mux_pkg::OFS_WORD1, 32'h0, 1'b0);
                chk_bus("word1", {23'h0, pats[j][19:10]}, r);
            end
        end
        // A write to a status word is dropped without error; an unmapped place errors.
        apb(1'b1, input_mux_pkg::OFS_WORD0, 32'hFFFFFFFF, 1'b1);
        chk_bus("ro write", 33'h0, {r[32], 32'h0});
        apb(1'b1, 8'h14, 32'hFFFFFFFF, 1'b1);
        chk_bus("bad write", {1'b1, 32'h0}, {r[32], 32'h0});
        apb(1'b0, 8'h14, 32'h0, 1'b1);
        chk_bus("bad read", {1'b1, 32'h0}, r);
        apb(1'b0, input_mux_pkg::OFS_WORD0, 32'h0, 1'b0);
        chk_bus("word0 kept", {23'h0, pats[2][9:0]}, r);
        // A second reset in mid-run must return every terminal to normal input.
        apb(1'b1, input_mux_pkg::OFS_CFG1, 32'h00000F55, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, input_mux_pkg::OFS_CFG1, 32'h0, 1'b0);
        chk_bus("cfg1 reset", 33'h0, r);
        drive(20'h3FFFF, 1'b0);
        chk_route(model_route(16'h0000, 16'h0000, 20'h3FFFF));
        end_of_test();
    end
endmodule : test_input_terminal_function_mux
